/* File: logic/interval_rtc_counter.v */
// Purpose: Time interval counter with real-time clock chain
// Assumes: SFR port synchronous to i_clk; i_por is a power-on reset
// Notes:   Crystal clock modelled as an enable pulse from a divider
`include "interval_rtc_map.vh"
`default_nettype none
module interval_rtc_counter #(
   parameter CLK_HZ  = `CLK_HZ,
   parameter XTAL_HZ = `XTAL_HZ
)(
   input  wire        i_clk,
   input  wire        i_rst,
   input  wire        i_por,
   input  wire        i_wr,
   input  wire        i_rd,
   input  wire [7:0]  i_addr,
   input  wire [7:0]  i_wdata,
   input  wire        i_irq_en,
   input  wire        i_power_down,
   output reg  [7:0]  o_rdata,
   output reg         o_irq,
   output reg         o_wake,
   output reg  [15:0] o_vector
);
   localparam XTAL_DIV = CLK_HZ / XTAL_HZ;
   // Least hold time rounds up to whole cycles
   // kHz scaling keeps the 50 MHz product inside 32-bit integer range
   localparam integer HOLD_CYC =
      (`HOLD_NS * (CLK_HZ / 1000) + 999999) / 1000000;
   localparam [10:0] HOLD_LAST = HOLD_CYC[10:0] - 11'h001;

   function sel;
      input [7:0] addr;
      input [7:0] off;
      begin
         sel = (addr == off);
      end
   endfunction

   // Control fields
   reg        res6_q;
   reg [1:0]  tb_q;
   reg        one_shot_q;
   reg        flag_q;
   reg        interval_count_enable_q;
   reg        time_clock_enable_q;
   reg [7:0]  target_q;
   reg [7:0]  icnt_q;

   reg        res6_d;
   reg [1:0]  tb_d;
   reg        one_shot_d;
   reg        flag_d;
   reg        interval_count_enable_d;
   reg        time_clock_enable_d;
   reg [7:0]  target_d;
   reg [7:0]  icnt_d;

   // Low-time counters for the two enables
   reg [10:0] time_clock_enable_low_q;
   reg [10:0] interval_count_enable_low_q;
   reg        time_clock_enable_cleared_q;
   reg [10:0] time_clock_enable_low_d;
   reg [10:0] interval_count_enable_low_d;
   reg        time_clock_enable_cleared_d;

   wire       xtick;
   wire       wr_ctrl;
   wire       warm;
   wire       chain_clr;
   wire       time_clock_enable_hold_done;
   wire       interval_count_enable_hold_done;
   wire       step;
   wire [7:0] icnt_nxt;
   wire       match;
   wire [7:0] ctrl_rd;
   wire [4:0] wrap;
   wire [4:0] stage_step;
   wire [4:0] stage_load;
   wire [39:0] stage_cnt;

   xtal_tick #(
      .DIV    (XTAL_DIV)
   ) u_tick (
      .i_clk  (i_clk),
      .i_rst  (i_por),
      .o_tick (xtick)
   );

   assign wr_ctrl = i_wr && sel(i_addr, `OFF_CTRL);
   assign warm    = i_rst && !i_por;

   assign time_clock_enable_hold_done = !time_clock_enable_q && (time_clock_enable_low_q == HOLD_LAST);
   assign interval_count_enable_hold_done = !interval_count_enable_q && (interval_count_enable_low_q == HOLD_LAST);

   // Power-on always clears; warm reset only when clock disabled
   assign chain_clr = i_por
                    || (i_rst && !time_clock_enable_q)
                    || (time_clock_enable_hold_done && !time_clock_enable_cleared_q);

   // Stage 0 prescaler, then fraction, seconds, minutes, hours
   genvar g;
   generate
      for (g = 0; g < 5; g = g + 1) begin : g_chain
         if (g == 0) begin : g_pre
            assign stage_step[g] = xtick && time_clock_enable_q;
            assign stage_load[g] = 1'b0;
         end else begin : g_reg
            localparam [31:0] OFFS = `OFF_CTRL + g;
            assign stage_step[g] = wrap[g-1];
            // Writes ignored while the clock runs
            assign stage_load[g] = i_wr && !time_clock_enable_q
               && sel(i_addr, OFFS[7:0]);
         end
         rtc_digit #(
            .MAXV     ((g == 0) ? `PRESCALE_MAX :
                       (g == 1) ? `FRAC_MAX :
                       (g == 2) ? `SEC_MAX :
                       (g == 3) ? `MIN_MAX :
                                  `HOUR_MAX)
         ) u_digit (
            .i_clk    (i_clk),
            .i_clr    (chain_clr),
            .i_load   (stage_load[g]),
            .i_ld_val (i_wdata),
            .i_step   (stage_step[g]),
            .o_count  (stage_cnt[g*8 +: 8]),
            .o_wrap   (wrap[g])
         );
      end
   endgenerate

   // Overflow of the chosen register clocks the interval counter
   assign step = (tb_q == 2'b00) ? wrap[0] :
                 (tb_q == 2'b01) ? wrap[1] :
                 (tb_q == 2'b10) ? wrap[2] :
                                   wrap[3];

   assign icnt_nxt = icnt_q + 8'h01;
   assign match    = interval_count_enable_q && step && (icnt_nxt == target_q);

   assign ctrl_rd = {1'b0, res6_q, tb_q, one_shot_q,
                     flag_q, interval_count_enable_q, time_clock_enable_q};

   always @* begin
      res6_d         = res6_q;
      tb_d           = tb_q;
      one_shot_d     = one_shot_q;
      flag_d         = flag_q;
      interval_count_enable_d         = interval_count_enable_q;
      time_clock_enable_d         = time_clock_enable_q;
      target_d       = target_q;
      icnt_d         = icnt_q;
      time_clock_enable_low_d     = time_clock_enable_low_q;
      interval_count_enable_low_d     = interval_count_enable_low_q;
      time_clock_enable_cleared_d = time_clock_enable_cleared_q;

      if (wr_ctrl) begin
         res6_d     = i_wdata[`BIT_RES6];
         tb_d       = i_wdata[`BIT_TB_HI:`BIT_TB_LO];
         one_shot_d = i_wdata[`BIT_ONESHOT];
         flag_d     = i_wdata[`BIT_FLAG];
         interval_count_enable_d     = i_wdata[`BIT_INTERVAL_COUNT_ENABLE];
         time_clock_enable_d     = i_wdata[`BIT_TIME_CLOCK_ENABLE];
      end
      if (i_wr && sel(i_addr, `OFF_TARGET))
         target_d = i_wdata;

      if (interval_count_enable_q && step) begin
         if (match) begin
            if (one_shot_q) begin
               icnt_d = icnt_nxt;
               // Software write of the enable in this cycle wins
               if (!wr_ctrl)
                  interval_count_enable_d = 1'b0;
            end else begin
               icnt_d = 8'h00;
            end
         end else begin
            icnt_d = icnt_nxt;
         end
      end
      if (interval_count_enable_hold_done)
         icnt_d = 8'h00;

      // Set wins over a clear written in the same cycle
      if (match)
         flag_d = 1'b1;

      if (time_clock_enable_q)
         time_clock_enable_low_d = 11'h000;
      else if (time_clock_enable_low_q != HOLD_LAST)
         time_clock_enable_low_d = time_clock_enable_low_q + 11'h001;

      if (interval_count_enable_q)
         interval_count_enable_low_d = 11'h000;
      else if (interval_count_enable_low_q != HOLD_LAST)
         interval_count_enable_low_d = interval_count_enable_low_q + 11'h001;

      // Clear once per low period so later writes stick
      if (time_clock_enable_q)
         time_clock_enable_cleared_d = 1'b0;
      else if (time_clock_enable_hold_done)
         time_clock_enable_cleared_d = 1'b1;
   end

   always @(posedge i_clk) begin
      if (i_por) begin
         res6_q         <= 1'b0;
         tb_q           <= 2'b00;
         one_shot_q     <= 1'b0;
         flag_q         <= 1'b0;
         interval_count_enable_q         <= 1'b0;
         time_clock_enable_q         <= 1'b0;
         target_q       <= `RST_BYTE;
         icnt_q         <= 8'h00;
         time_clock_enable_low_q     <= 11'h000;
         interval_count_enable_low_q     <= 11'h000;
         time_clock_enable_cleared_q <= 1'b1;
      end else if (warm) begin
         res6_q         <= 1'b0;
         tb_q           <= 2'b00;
         one_shot_q     <= 1'b0;
         flag_q         <= 1'b0;
         interval_count_enable_q         <= 1'b0;
         time_clock_enable_q         <= time_clock_enable_q;
         target_q       <= `RST_BYTE;
         icnt_q         <= 8'h00;
         time_clock_enable_low_q     <= 11'h000;
         interval_count_enable_low_q     <= 11'h000;
         time_clock_enable_cleared_q <= 1'b1;
      end else begin
         res6_q         <= res6_d;
         tb_q           <= tb_d;
         one_shot_q     <= one_shot_d;
         flag_q         <= flag_d;
         interval_count_enable_q         <= interval_count_enable_d;
         time_clock_enable_q         <= time_clock_enable_d;
         target_q       <= target_d;
         icnt_q         <= icnt_d;
         time_clock_enable_low_q     <= time_clock_enable_low_d;
         interval_count_enable_low_q     <= interval_count_enable_low_d;
         time_clock_enable_cleared_q <= time_clock_enable_cleared_d;
      end
   end

   // Registered read port; unmapped addresses read zero
   always @(posedge i_clk) begin
      if (i_rst || i_por) begin
         o_rdata <= 8'h00;
      end else if (i_rd) begin
         case (i_addr)
            `OFF_CTRL:   o_rdata <= ctrl_rd;
            `OFF_FRAC:   o_rdata <= stage_cnt[15:8];
            `OFF_SEC:    o_rdata <= stage_cnt[23:16];
            `OFF_MIN:    o_rdata <= stage_cnt[31:24];
            `OFF_HOUR:   o_rdata <= stage_cnt[39:32];
            `OFF_TARGET: o_rdata <= target_q;
            default:     o_rdata <= 8'h00;
         endcase
      end
   end

   // Interrupt and wake follow the flag by one cycle
   always @(posedge i_clk) begin
      if (i_rst || i_por) begin
         o_irq    <= 1'b0;
         o_wake   <= 1'b0;
         o_vector <= 16'h0000;
      end else begin
         o_irq    <= flag_q && i_irq_en;
         o_wake   <= flag_q && i_irq_en && i_power_down;
         o_vector <= (flag_q && i_irq_en && i_power_down)
                     ? `IRQ_VECTOR : 16'h0000;
      end
   end
endmodule // interval_rtc_counter
`default_nettype wire

/* File: logic/interval_rtc_map.vh */
// Purpose: Offsets, fields, reset values and timing for the interval RTC
// Assumes: 50 MHz system clock, 32768 Hz crystal rate
// Notes:   Definitions only
`ifndef INTERVAL_RTC_MAP_VH
`define INTERVAL_RTC_MAP_VH

`define OFF_CTRL        8'hA1
`define OFF_FRAC        8'hA2
`define OFF_SEC         8'hA3
`define OFF_MIN         8'hA4
`define OFF_HOUR        8'hA5
`define OFF_TARGET      8'hA6

`define BIT_TIME_CLOCK_ENABLE        0
`define BIT_INTERVAL_COUNT_ENABLE        1
`define BIT_FLAG        2
`define BIT_ONESHOT     3
`define BIT_TB_LO       4
`define BIT_TB_HI       5
`define BIT_RES6        6

`define RST_BYTE        8'h00
`define PRESCALE_MAX    8'hFF
`define FRAC_MAX        8'h7F
`define SEC_MAX         8'h3B
`define MIN_MAX         8'h3B
`define HOUR_MAX        8'h17

`define IRQ_VECTOR      16'h0053
`define HOLD_NS         30500
`define CLK_HZ          50000000
`define XTAL_HZ         32768

`endif

/* File: logic/rtc_digit.v */
// Purpose: Wrapping counter stage of the time chain
// Assumes: Load only while the chain is stopped
// Notes:   Wrap is combinational so carries ripple in one cycle
`include "interval_rtc_map.vh"
`default_nettype none
module rtc_digit #(
   parameter [7:0]  MAXV = 8'h3B
)(
   input  wire       i_clk,
   input  wire       i_clr,
   input  wire       i_load,
   input  wire [7:0] i_ld_val,
   input  wire       i_step,
   output reg  [7:0] o_count,
   output wire       o_wrap
);
   assign o_wrap = i_step && (o_count == MAXV);

   always @(posedge i_clk) begin
      if (i_clr)
         o_count <= `RST_BYTE;
      else if (i_load)
         o_count <= i_ld_val;
      else if (o_wrap)
         o_count <= `RST_BYTE;
      else if (i_step)
         o_count <= o_count + 8'h01;
   end
endmodule // rtc_digit
`default_nettype wire

/* File: logic/xtal_tick.v */
// Purpose: One-cycle enable at the crystal rate
// Assumes: DIV at least 2
// Notes:   Rate error of integer division is accepted
`default_nettype none
module xtal_tick #(
   parameter        DIV = 1525
)(
   input  wire      i_clk,
   input  wire      i_rst,
   output reg       o_tick
);
   reg [10:0] cnt_q;

   always @(posedge i_clk) begin
      if (i_rst) begin
         cnt_q  <= 11'h000;
         o_tick <= 1'b0;
      end else if (cnt_q == DIV[10:0] - 11'h001) begin
         cnt_q  <= 11'h000;
         o_tick <= 1'b1;
      end else begin
         cnt_q  <= cnt_q + 11'h001;
         o_tick <= 1'b0;
      end
   end
endmodule // xtal_tick
`default_nettype wire

/* File: verif/interval_rtc_counter_props.sv */
// Purpose: Port-level properties of the interval RTC
// Assumes: Synchronous resets sampled on i_clk
// Notes:   Bound from the bench top file
`default_nettype none
module interval_rtc_counter_props #(
   parameter CLK_HZ  = 50000000,
   parameter XTAL_HZ = 32768
)(
   input wire logic        i_clk,
   input wire logic        i_rst,
   input wire logic        i_por,
   input wire logic        i_wr,
   input wire logic        i_rd,
   input wire logic [7:0]  i_addr,
   input wire logic        i_irq_en,
   input wire logic        i_power_down,
   input wire logic [7:0]  o_rdata,
   input wire logic        o_irq,
   input wire logic        o_wake,
   input wire logic [15:0] o_vector
);
   timeunit 1ns;
   timeprecision 1ns;
   default clocking cb @(posedge i_clk); endclocking
   default disable iff (i_rst || i_por);
   logic wr_ctl;
   assign wr_ctl = i_wr && i_addr == 8'hA1;

   property p_irq_off; !i_irq_en |=> !o_irq; endproperty
   a_irq_off: assert property (p_irq_off) else $error("irq no enable");
   property p_stick; o_irq && i_irq_en && !$past(wr_ctl) |=> o_irq;
   endproperty
   a_stick: assert property (p_stick) else $error("flag dropped");
   property p_wake_pd; !i_power_down |=> !o_wake; endproperty
   a_wake_pd: assert property (p_wake_pd) else $error("wake awake");
   property p_wake_irq; o_wake |-> o_irq && $past(i_power_down); endproperty
   a_wake_irq: assert property (p_wake_irq) else $error("wake no irq");
   property p_vec; o_vector == (o_wake ? 16'h0053 : 16'h0000); endproperty
   a_vec: assert property (p_vec) else $error("bad vector");
   property p_b7; i_rd && i_addr == 8'hA1 |=> !o_rdata[7]; endproperty
   a_b7: assert property (p_b7) else $error("bit 7 set");
   property p_por;
      @(posedge i_clk) disable iff (1'b0)
      i_por |=> o_rdata == 8'h00 && !o_irq && !o_wake;
   endproperty
   a_por: assert property (p_por) else $error("por not clear");
   property p_target; $fell(i_rst) && i_rd && i_addr == 8'hA6
      |=> o_rdata == 8'h00; endproperty
   a_target: assert property (p_target) else $error("target kept");
endmodule // interval_rtc_counter_props
`default_nettype wire

/* File: verif/interval_rtc_counter_tb_top.sv */
// Purpose: Self-checking bench for the interval RTC
// Assumes: Divider of 2, so one fraction step is 512 clocks
// Notes:   Long timebases reached by preloading the time chain
`default_nettype none
module interval_rtc_counter_tb_top;
   timeunit 1ns;
   timeprecision 1ns;
   localparam int STEP = 512;
   logic        i_clk = 1'b0;
   logic        i_rst, i_por, i_wr, i_rd, i_irq_en, i_power_down;
   logic [7:0]  i_addr, i_wdata, o_rdata;
   logic        o_irq, o_wake;
   logic [15:0] o_vector;
   logic [31:0] seed = 32'h0000_30e1;
   int          fail_count = 0;
   int          total_checks = 0;
   int          tm[4] = '{127, 59, 59, 23};
   int          n, t;
   int          mdl[4];
   logic        time_clock_enable_m = 1'b0;

   always #10 i_clk = ~i_clk;

   interval_rtc_counter #(.CLK_HZ(65536), .XTAL_HZ(32768))
   interval_rtc_counter_inst (.i_clk(i_clk), .i_rst(i_rst), .i_por(i_por),
      .i_wr(i_wr), .i_rd(i_rd), .i_addr(i_addr), .i_wdata(i_wdata),
      .i_irq_en(i_irq_en), .i_power_down(i_power_down), .o_rdata(o_rdata),
      .o_irq(o_irq), .o_wake(o_wake), .o_vector(o_vector));

   function automatic logic [31:0] rnd();
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
      return seed;
   endfunction

   task automatic summarize;
      $display("checks %0d mismatches %0d", total_checks, fail_count);
      if (fail_count == 0 && total_checks > 0) $display("SIMULATION PASSED");
      else $display("SIMULATION FAILED");
      $finish;
   endtask

   task automatic chk(input string nm, input logic [15:0] got, exp);
      total_checks++;
      if (got !== exp) begin
         fail_count++;
         $display("unexpected %s expected %h seen %h", nm, exp, got);
      end
   endtask

   // Strobes drop for a full cycle so back-to-back calls never collide
   task automatic wr(input logic [7:0] a, d);
      if (a == 8'hA1) time_clock_enable_m = d[0];
      if (a >= 8'hA2 && a <= 8'hA5 && !time_clock_enable_m) mdl[a - 8'hA2] = d;
      i_wr = 1'b1;
      i_addr = a;
      i_wdata = d;
      @(negedge i_clk);
      i_wr = 1'b0;
      @(negedge i_clk);
   endtask

   task automatic rd(input logic [7:0] a, exp);
      i_rd = 1'b1;
      i_addr = a;
      @(negedge i_clk);
      i_rd = 1'b0;
      chk("rdata", 16'(o_rdata), 16'(exp));
      @(negedge i_clk);
   endtask

   task automatic cyc(input int c);
      repeat (c) @(negedge i_clk);
   endtask

   task automatic wait_irq(input int lim, output int c);
      c = 0;
      while (o_irq !== 1'b1 && c < lim) begin
         @(negedge i_clk);
         c++;
      end
      if (c >= lim) begin
         fail_count++;
         $display("unexpected irq timeout expected 1 seen 0");
         summarize();
      end
   endtask

   // Chain held stopped long enough to clear, then one target loaded
   task automatic restart(input logic [7:0] tgt);
      wr(8'hA1, 8'h40);
      cyc(1600);
      wr(8'hA6, tgt);
   endtask

   initial begin
      {i_rst, i_por, i_wr, i_rd, i_irq_en, i_power_down} = 6'b110010;
      i_addr = 8'h00;
      i_wdata = 8'h00;
      cyc(16);
      {i_rst, i_por} = 2'b00;
      for (int a = 1; a < 7; a++) rd(8'(8'hA0 + a), 8'h00);
      rd(8'hA7 | 8'(rnd()), 8'h00);
      for (int i = 0; i < 4; i++) wr(8'(8'hA2 + i), 8'(tm[i]));
      for (int i = 0; i < 4; i++) rd(8'(8'hA2 + i), 8'(mdl[i]));
      wr(8'hA1, 8'h41);
      wr(8'hA3, 8'(rnd()));
      cyc(600);
      for (int i = 0; i < 4; i++) rd(8'(8'hA2 + i), 8'h00);
      cyc(500);
      wr(8'hA6, 8'h5A);
      i_rst = 1'b1;
      cyc(2);
      i_rst = 1'b0;
      rd(8'hA6, 8'h00);
      rd(8'hA2, 8'h01);
      restart(8'h01);
      rd(8'hA2, 8'h00);
      for (int k = 0; k < 4; k++) begin
         restart(8'h01);
         wr(8'hA2, 8'h7F);
         wr(8'hA3, k > 1 ? 8'h3B : 8'h00);
         wr(8'hA4, k > 2 ? 8'h3B : 8'h00);
         wr(8'hA1, 8'(8'h43 | (k << 4)));
         wait_irq(700, n);
         chk("timebase", 16'(n > 400), 16'h0001);
         wr(8'(8'hA1), 8'(8'h43 | (k << 4)));
         cyc(600);
         chk("timebase", 16'(o_irq), 16'(k == 0));
      end
      t = 1 + int'(rnd() % 3);
      restart(8'(t));
      wr(8'hA1, 8'h43);
      wait_irq(2000, n);
      wr(8'hA1, 8'h43);
      wait_irq(2000, n);
      chk("period", 16'(n + 2), 16'(t * STEP));
      i_power_down = 1'b1;
      cyc(2);
      chk("wake", 16'(o_wake), 16'h0001);
      chk("vector", o_vector, 16'h0053);
      i_irq_en = 1'b0;
      cyc(2);
      chk("irq", 16'({o_irq, o_wake}), 16'h0000);
      i_irq_en = 1'b1;
      i_power_down = 1'b0;
      cyc(2);
      chk("irq", 16'(o_irq), 16'h0001);
      restart(8'h01);
      wr(8'hA1, 8'h4B);
      wait_irq(700, n);
      rd(8'hA1, 8'h4D);
      wr(8'hA1, 8'h49);
      cyc(1200);
      chk("irq", 16'(o_irq), 16'h0000);
      wr(8'hA1, 8'h4B);
      wait_irq(700, n);
      summarize();
   end
endmodule // interval_rtc_counter_tb_top

bind interval_rtc_counter interval_rtc_counter_props #(
   .CLK_HZ(CLK_HZ), .XTAL_HZ(XTAL_HZ)) props_inst (.i_clk(i_clk),
   .i_rst(i_rst), .i_por(i_por), .i_wr(i_wr), .i_rd(i_rd),
   .i_addr(i_addr), .i_irq_en(i_irq_en), .i_power_down(i_power_down),
   .o_rdata(o_rdata), .o_irq(o_irq), .o_wake(o_wake),
   .o_vector(o_vector));
`default_nettype wire
